// ===== rtl/cirb_config_index_register_bank.sv
`timescale 1ns/100ps
module cirb_config_index_register_bank
  import cirb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       hostResetIn,
  input  wire logic       altBaseSel,
  input  wire logic [9:0] hostAddr,
  input  wire logic [7:0] hostDataIn,
  input  wire logic       hostWriteN,
  input  wire logic       hostReadN,
  output logic      [7:0] hostDataOut,
  output logic            hostDataOeN,
  output cirb_ctrl_type   ctrlOut
);

  // Two-stage synchronisers for every pin input.
  cirb_host_type hostMeta_reg, hostSync_reg, hostPrev_reg, hostHeld_reg;
  logic [1:0]    hostResetSync_reg, altSelSync_reg;
  cirb_host_type hostNow, hostHeld_next;

  assign hostNow = '{addr: hostAddr, data: hostDataIn, writeN: hostWriteN, readN: hostReadN};

  // Sync stages; the first stage is never read by logic.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostMeta_reg      <= '{addr: 10'h000, data: 8'h00, writeN: 1'b1, readN: 1'b1};
      hostSync_reg      <= '{addr: 10'h000, data: 8'h00, writeN: 1'b1, readN: 1'b1};
      hostPrev_reg      <= '{addr: 10'h000, data: 8'h00, writeN: 1'b1, readN: 1'b1};
      hostHeld_reg      <= '{addr: 10'h000, data: 8'h00, writeN: 1'b1, readN: 1'b1};
      hostResetSync_reg <= 2'h0;
      altSelSync_reg    <= 2'h0;
    end else begin
      hostMeta_reg      <= hostNow;
      hostSync_reg      <= hostMeta_reg;
      hostPrev_reg      <= hostSync_reg;
      hostHeld_reg      <= hostHeld_next;
      hostResetSync_reg <= {hostResetSync_reg[0], hostResetIn};
      altSelSync_reg    <= {altSelSync_reg[0], altBaseSel};
    end
  end

  // Address and data follow the bus while the write strobe is low and are held once it rises, because ISA data is only
  // guaranteed up to the trailing edge and the synchronised copy may already have moved.
  always_comb begin
    hostHeld_next = hostHeld_reg;
    if (!hostSync_reg.writeN) begin
      hostHeld_next = hostSync_reg;
    end
  end

  // Port decoding; the data port test serves both the write and the read path, the index port test only the write path.
  function automatic logic isIndexPort(input logic [9:0] a, input logic alt);
    isIndexPort = alt ? (a == IDX_PORT_ALT) : (a == IDX_PORT_PRI);
  endfunction

  function automatic logic isDataPort(input logic [9:0] a, input logic alt);
    isDataPort = alt ? (a == DATA_PORT_ALT) : (a == DATA_PORT_PRI);
  endfunction

  logic altSel, hostResetPulse, writeDone, readStart, readEnd;
  logic idxWrite, dataWrite, dataRead, lockedIdx;

  assign altSel         = altSelSync_reg[1];
  assign hostResetPulse = hostResetSync_reg[1];
  assign writeDone      = hostSync_reg.writeN && !hostPrev_reg.writeN;
  assign readStart      = !hostSync_reg.readN && hostPrev_reg.readN;
  assign readEnd        = hostSync_reg.readN;
  assign idxWrite       = writeDone && isIndexPort(hostHeld_reg.addr, altSel);
  assign dataWrite      = writeDone && isDataPort(hostHeld_reg.addr, altSel);
  assign dataRead       = readStart && isDataPort(hostSync_reg.addr, altSel);

  // Mode, index and register state.
  logic       configMode_reg, configMode_next;
  logic       keyArmed_reg, keyArmed_next;
  logic [7:0] index_reg, index_next;
  logic [7:0] deviceEnable_reg, deviceEnable_next;
  logic [7:0] portLock_reg, portLock_next;

  // Registers in the lock range become unreachable once the lock bit is cleared.
  assign lockedIdx = !portLock_reg[CONFIG_LOCK_BIT] && (index_reg <= LOCK_RANGE_END);

  // Key sequence, index loading and register writes.
  always_comb begin
    configMode_next   = configMode_reg;
    keyArmed_next     = keyArmed_reg;
    index_next        = index_reg;
    deviceEnable_next = deviceEnable_reg;
    portLock_next     = portLock_reg;
    if (idxWrite) begin
      if (!configMode_reg) begin
        // Any other index port write between the two keys breaks the sequence.
        keyArmed_next = 1'b0;
        if (hostHeld_reg.data == KEY_ENTER) begin
          if (keyArmed_reg) begin
            configMode_next = 1'b1;
          end else begin
            keyArmed_next = 1'b1;
          end
        end
      end else if (hostHeld_reg.data == KEY_EXIT) begin
        configMode_next = 1'b0;
      end else begin
        index_next = hostHeld_reg.data;
      end
    end else if (dataWrite && configMode_reg && !lockedIdx) begin
      if (index_reg == IDX_DEVICE_ENABLE) begin
        deviceEnable_next = (hostHeld_reg.data & DEVICE_ENABLE_WMASK)
                            | DEVICE_ENABLE_FIXED;
      end else if (index_reg == IDX_PORT_LOCK) begin
        portLock_next = (hostHeld_reg.data & PORT_LOCK_WMASK)
                        | PORT_LOCK_FIXED;
        // Software can only clear the lock bit, never set it; a host reset sets it again.
        portLock_next[CONFIG_LOCK_BIT] = portLock_reg[CONFIG_LOCK_BIT]
                                         & hostHeld_reg.data[CONFIG_LOCK_BIT];
      end
    end
    // Host reset leaves the settings alone but reopens the lock and drops the mode.
    if (hostResetPulse) begin
      portLock_next[CONFIG_LOCK_BIT] = 1'b1;
      configMode_next                = 1'b0;
      keyArmed_next                  = 1'b0;
    end
  end

  // Only the power-up reset restores the defaults.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      configMode_reg   <= 1'b0;
      keyArmed_reg     <= 1'b0;
      index_reg        <= INDEX_RST;
      deviceEnable_reg <= DEVICE_ENABLE_RST;
      portLock_reg     <= PORT_LOCK_RST;
    end else begin
      configMode_reg   <= configMode_next;
      keyArmed_reg     <= keyArmed_next;
      index_reg        <= index_next;
      deviceEnable_reg <= deviceEnable_next;
      portLock_reg     <= portLock_next;
    end
  end

  // Read path: the data bus is driven from the start to the end of a data port read in configuration mode.
  logic [7:0]    dataOut_next;
  logic          dataOeN_next;
  cirb_ctrl_type ctrl_next;

  always_comb begin
    dataOut_next = hostDataOut;
    dataOeN_next = hostDataOeN;
    if (dataRead && configMode_reg) begin
      dataOeN_next = 1'b0;
      if (lockedIdx) begin
        dataOut_next = 8'h00;
      end else if (index_reg == IDX_DEVICE_ENABLE) begin
        dataOut_next = deviceEnable_reg;
      end else if (index_reg == IDX_PORT_LOCK) begin
        dataOut_next = portLock_reg;
      end else begin
        dataOut_next = 8'h00;
      end
    end else if (readEnd) begin
      dataOeN_next = 1'b1;
    end
  end

  // Control outputs; the floppy and printer bits only gate pins, decode is untouched.
  always_comb begin
    ctrl_next.driveIfEnable       = deviceEnable_reg[1:0] == PIN_FUNC_DRIVE;
    ctrl_next.altIrEnable         = deviceEnable_reg[1:0] == PIN_FUNC_ALT_IR;
    ctrl_next.drivePullupEnable   = !deviceEnable_reg[1];
    ctrl_next.floppyPowerOn       = deviceEnable_reg[FLOPPY_POWER_BIT];
    ctrl_next.parallelPowerOn     = portLock_reg[PAR_POWER_BIT];
    ctrl_next.parallelPrinterMode = portLock_reg[PAR_PRINTER_BIT];
    ctrl_next.validFlag           = deviceEnable_reg[VALID_FLAG_BIT];
    ctrl_next.configMode          = configMode_reg;
  end

  // Output flops; reset values match the power-up register contents.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hostDataOut <= 8'h00;
      hostDataOeN <= 1'b1;
      ctrlOut     <= '{driveIfEnable: 1'b0, altIrEnable: 1'b0, drivePullupEnable: 1'b1,
                       floppyPowerOn: 1'b1, parallelPowerOn: 1'b1,
                       parallelPrinterMode: 1'b1, validFlag: 1'b0, configMode: 1'b0};
    end else begin
      hostDataOut <= dataOut_next;
      hostDataOeN <= dataOeN_next;
      ctrlOut     <= ctrl_next;
    end
  end

endmodule

// ===== rtl/cirb_pkg.sv
package cirb_pkg;

  // Host port addresses, primary and alternate.
  localparam logic [9:0] IDX_PORT_PRI  = 10'h3f0;
  localparam logic [9:0] DATA_PORT_PRI = 10'h3f1;
  localparam logic [9:0] IDX_PORT_ALT  = 10'h370;
  localparam logic [9:0] DATA_PORT_ALT = 10'h371;

  // Mode entry and exit keys written to the index port.
  localparam logic [7:0] KEY_ENTER = 8'h55;
  localparam logic [7:0] KEY_EXIT  = 8'haa;

  // Register indices.
  localparam logic [7:0] IDX_DEVICE_ENABLE = 8'h00;
  localparam logic [7:0] IDX_PORT_LOCK     = 8'h01;
  localparam logic [7:0] LOCK_RANGE_END    = 8'h0f;

  // Power-up values.
  localparam logic [7:0] DEVICE_ENABLE_RST = 8'h28;
  localparam logic [7:0] PORT_LOCK_RST     = 8'h9c;
  localparam logic [7:0] INDEX_RST         = 8'h00;

  // Writable bit masks and fixed reserved values.
  localparam logic [7:0] DEVICE_ENABLE_WMASK = 8'h8b;
  localparam logic [7:0] DEVICE_ENABLE_FIXED = 8'h20;
  localparam logic [7:0] PORT_LOCK_WMASK     = 8'h8c;
  localparam logic [7:0] PORT_LOCK_FIXED     = 8'h10;

  // Field positions.
  localparam int FLOPPY_POWER_BIT  = 3;
  localparam int VALID_FLAG_BIT    = 7;
  localparam int PAR_POWER_BIT     = 2;
  localparam int PAR_PRINTER_BIT   = 3;
  localparam int CONFIG_LOCK_BIT   = 7;

  // Pin function select codes.
  localparam logic [1:0] PIN_FUNC_DRIVE  = 2'h2;
  localparam logic [1:0] PIN_FUNC_ALT_IR = 2'h3;

  // Host port sample.
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
    logic       writeN;
    logic       readN;
  } cirb_host_type;

  // Control outputs derived from the registers.
  typedef struct packed {
    logic driveIfEnable;
    logic altIrEnable;
    logic drivePullupEnable;
    logic floppyPowerOn;
    logic parallelPowerOn;
    logic parallelPrinterMode;
    logic validFlag;
    logic configMode;
  } cirb_ctrl_type;

endpackage

// ===== sim/cirb_config_index_register_bank_tb.sv
`timescale 1ns/100ps
`define CHECK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s expected %h seen %h", n, e, g); end end
module cirb_config_index_register_bank_tb;
  import cirb_pkg::*;
  logic          ref_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          hostResetIn = 1'b0;
  logic          altBaseSel = 1'b0;
  logic    [9:0] hostAddr;
  logic    [7:0] hostDataIn, hostDataOut, rd;
  logic          hostWriteN, hostReadN, hostDataOeN, drv;
  cirb_ctrl_type ctrlOut;
  int            errors = 0;
  int            checksDone = 0;
  cirb_config_index_register_bank DUT (.ref_clk, .sys_rst, .hostResetIn, .altBaseSel,
    .hostAddr, .hostDataIn, .hostWriteN, .hostReadN, .hostDataOut, .hostDataOeN, .ctrlOut);
  cirb_host_model host (.ref_clk, .hostDataOut, .hostDataOeN, .hostAddr, .hostDataIn,
    .hostWriteN, .hostReadN);
  // Free-running clock and a watchdog far beyond the expected run time.
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #100000;
    errors++;
    final_report();
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic regChk(input string n, input logic [7:0] i, input logic [7:0] e);
    host.regRead(i, rd, drv);
    `CHECK(n, e, rd)
  endtask
  task automatic testDefaults();
    `CHECK("controls", 8'h3c, ctrlOut)
    host.enterCfg();
    regChk("device enable", IDX_DEVICE_ENABLE, 8'h28);
    regChk("port lock", IDX_PORT_LOCK, 8'h9c);
    host.ioRead(host.base, rd, drv);
    `CHECK("index port drive", 1'b0, drv)
    regChk("unknown index", 8'h22, 8'h00);
    $display("defaults test done");
  endtask
  // Every pin function code, with all reserved bits written as ones.
  task automatic testDeviceEnable();
    for (int p = 0; p < 4; p++) begin
      host.regWrite(IDX_DEVICE_ENABLE, 8'hfc | 8'(p));
      regChk("device enable", IDX_DEVICE_ENABLE, 8'ha8 | 8'(p));
      `CHECK("drive enable", p == 2, ctrlOut.driveIfEnable)
      `CHECK("alt ir enable", p == 3, ctrlOut.altIrEnable)
      `CHECK("pull-ups", p < 2, ctrlOut.drivePullupEnable)
      `CHECK("valid flag", 1'b1, ctrlOut.validFlag)
    end
    host.regWrite(IDX_DEVICE_ENABLE, 8'h00);
    regChk("device enable", IDX_DEVICE_ENABLE, 8'h20);
    `CHECK("floppy power", 1'b0, ctrlOut.floppyPowerOn)
    $display("device enable test done");
  endtask
  task automatic testPortLock();
    host.regWrite(IDX_PORT_LOCK, 8'hf3);
    regChk("port lock", IDX_PORT_LOCK, 8'h90);
    `CHECK("parallel power", 1'b0, ctrlOut.parallelPowerOn)
    `CHECK("printer mode", 1'b0, ctrlOut.parallelPrinterMode)
    host.regWrite(IDX_PORT_LOCK, 8'h9c);
    $display("port lock test done");
  endtask
  // Leaving the mode must hide the registers; then the alternate ports are used.
  task automatic testOutside();
    host.ioWrite(host.base, KEY_EXIT);
    host.ioWrite(DATA_PORT_PRI, 8'hff);
    host.ioRead(DATA_PORT_PRI, rd, drv);
    `CHECK("drive outside mode", 1'b0, drv)
    altBaseSel = 1'b1;
    host.base = IDX_PORT_ALT;
    host.enterCfg();
    regChk("alt device enable", IDX_DEVICE_ENABLE, 8'h20);
    $display("outside mode test done");
  endtask
  task automatic testLock();
    host.regWrite(IDX_PORT_LOCK, 8'h1c);
    host.regWrite(IDX_DEVICE_ENABLE, 8'hff);
    host.regWrite(IDX_PORT_LOCK, 8'h9c);
    regChk("locked read", IDX_DEVICE_ENABLE, 8'h00);
    @(negedge ref_clk) hostResetIn = 1'b1;
    repeat (8) @(negedge ref_clk);
    hostResetIn = 1'b0;
    `CHECK("mode after hard reset", 1'b0, ctrlOut.configMode)
    host.enterCfg();
    regChk("lock after hard reset", IDX_PORT_LOCK, 8'h9c);
    regChk("kept over hard reset", IDX_DEVICE_ENABLE, 8'h20);
    sys_rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst = 1'b0;
    host.enterCfg();
    regChk("power-up value", IDX_DEVICE_ENABLE, 8'h28);
    $display("lock test done");
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    sys_rst = 1'b0;
    testDefaults();
    testDeviceEnable();
    testPortLock();
    testOutside();
    testLock();
    final_report();
  end
endmodule

// ===== sim/cirb_host_model.sv
`timescale 1ns/100ps
module cirb_host_model
  import cirb_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] hostDataOut,
  input  wire logic       hostDataOeN,
  output logic      [9:0] hostAddr,
  output logic      [7:0] hostDataIn,
  output logic            hostWriteN,
  output logic            hostReadN
);
  logic [9:0] base = IDX_PORT_PRI;
  // Idle bus at time zero with both strobes high.
  initial begin
    hostAddr = 10'h000;
    hostDataIn = 8'h00;
    hostWriteN = 1'b1;
    hostReadN = 1'b1;
  end
  // Strobes stay low and high long enough to get through the pin synchronisers.
  task automatic ioWrite(input logic [9:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    hostAddr = a;
    hostDataIn = d;
    hostWriteN = 1'b0;
    repeat (4) @(negedge ref_clk);
    hostWriteN = 1'b1;
    repeat (3) @(negedge ref_clk);
    hostAddr = ~a;  // Released lines flip so a stale value cannot pass for a held one.
    hostDataIn = ~d;
    repeat (3) @(negedge ref_clk);
  endtask
  // Read data is taken at a falling edge well after the answer is due, never in the
  // time step of the rising edge that launches it; then the strobe is lifted.
  task automatic ioRead(input logic [9:0] a, output logic [7:0] d, output logic drv);
    @(negedge ref_clk);
    hostAddr = a;
    hostReadN = 1'b0;
    repeat (5) @(negedge ref_clk);
    drv = (hostDataOeN === 1'b0);
    d = hostDataOut;
    @(negedge ref_clk);
    hostReadN = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic enterCfg();
    ioWrite(base, KEY_ENTER);
    ioWrite(base, KEY_ENTER);
  endtask
  task automatic regWrite(input logic [7:0] i, input logic [7:0] d);
    ioWrite(base, i);
    ioWrite(base + 10'h001, d);
  endtask
  task automatic regRead(input logic [7:0] i, output logic [7:0] d, output logic drv);
    ioWrite(base, i);
    ioRead(base + 10'h001, d, drv);
  endtask
endmodule

// ===== sim/cirb_monitor.sv
`timescale 1ns/100ps
module cirb_monitor
  import cirb_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  input wire logic          hostResetIn,
  input wire logic          altBaseSel,
  input wire logic    [9:0] hostAddr,
  input wire logic          hostWriteN,
  input wire logic          hostReadN,
  input wire logic          hostDataOeN,
  input wire cirb_ctrl_type ctrlOut
);
  // One clock domain, so power-up reset silences every check at once.
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [9:0] dataPort;
  // The data port moves with the base select pin.
  assign dataPort = altBaseSel ? DATA_PORT_ALT : DATA_PORT_PRI;
  pull_up_a:
    assert property (ctrlOut.drivePullupEnable != (ctrlOut.driveIfEnable | ctrlOut.altIrEnable))
      else $error("pull-ups disagree with pin function");
  pin_excl_a: assert property (!(ctrlOut.driveIfEnable && ctrlOut.altIrEnable))
    else $error("drive and alternate pins both enabled");
  oe_release_a: assert property (hostReadN [*5] |-> hostDataOeN)
    else $error("data bus driven without a read");
  idx_noread_a: assert property ((!hostAddr[0] && !hostReadN) [*5] |-> hostDataOeN)
    else $error("index port read drove the bus");
  rd_answer_a:
    assert property ($fell(hostReadN) && ctrlOut.configMode && hostAddr == dataPort
      |-> ##[3:4] !hostDataOeN) else $error("data port read not answered in time");
  pwr_default_a: assert property ($fell(sys_rst) |-> ctrlOut == 8'h3c)
    else $error("controls not at power-up values");
  quiet_ctrl_a: assert property ((hostWriteN && !hostResetIn) [*8] |-> $stable(ctrlOut))
    else $error("controls moved with no write");
  hard_rst_a: assert property (hostResetIn [*6] |-> !ctrlOut.configMode)
    else $error("hard reset left configuration mode on");
endmodule
bind cirb_config_index_register_bank cirb_monitor mon (.ref_clk, .sys_rst, .hostResetIn,
  .altBaseSel, .hostAddr, .hostWriteN, .hostReadN, .hostDataOeN, .ctrlOut);
